// *** bbr_remapper.sv ***
`timescale 1ns/10ps
module bbr_remapper
  import bbr_pkg::*;
(
  input wire logic clock,           // 100 MHz bus clock
  input wire logic rst,             // Async reset, active high
  input wire bbr_req_s cpuReq,      // Processor request
  input wire logic cpuValid,        // Processor request valid
  output logic cpuReady,            // Request taken / answered
  output logic [31:0] cpuRdata,     // Read data
  output logic cpuError,            // Refused access
  output bbr_req_s memReq,          // Memory request
  output logic memValid,            // Memory request valid
  input wire logic memReady,        // Memory accepted and answered
  input wire logic [31:0] memRdata  // Memory read data
);

  // ------------------------------------------------------------
  // Region decode
  // ------------------------------------------------------------
  wire logic [31:0] aBase = {cpuReq.addr[31:ALIAS_SPAN_BITS], {ALIAS_SPAN_BITS{1'b0}}};
  wire logic inSramAlias = (aBase == SRAM_ALIAS_BASE);
  wire logic inPeriAlias = (aBase == PERI_ALIAS_BASE);
  // Fetches into the SRAM alias pass through untouched
  wire logic remap = (inSramAlias | inPeriAlias) & ~cpuReq.fetch;
  // Peripheral alias is execute-never
  wire logic refuse = inPeriAlias & cpuReq.fetch;
  wire logic [BAND_SPAN_BITS-1:0] byteOff =
    cpuReq.addr[BYTE_FIELD_LSB+BAND_SPAN_BITS-1:BYTE_FIELD_LSB];
  wire logic [2:0] bitNum = cpuReq.addr[BIT_FIELD_LSB+2:BIT_FIELD_LSB];
  wire logic [31:0] bandBase = inSramAlias ? SRAM_BAND_BASE : PERI_BAND_BASE;
  wire logic [31:0] bandAddr = bandBase | {12'h000, byteOff};

  // ------------------------------------------------------------
  // Captured remap request
  // ------------------------------------------------------------
  bbr_state_e state_q, state_d;
  logic [31:0] addr_q;
  logic [1:0] size_q;
  logic [2:0] bit_q;
  logic wr_q, val_q;
  logic [31:0] word_q;
  logic [31:0] merged;
  logic picked;

  // Word-aligned address with the byte lane ORed back in for memory, byte lane for the lane picker; size kept for memory
  wire logic [31:0] wordAddr = {addr_q[31:2], 2'b00};
  wire logic [1:0] laneSel = addr_q[1:0];

  // The picker reads the live word during the read half and the held
  // word during the write half, so one lane helper serves both
  wire logic [31:0] laneWord = (state_q == ST_READ) ? memRdata : word_q;

  bbr_lane lane (
    .byteSel(laneSel),
    .bitSel(bit_q),
    .word(laneWord),
    .newBit(val_q),
    .merged(merged),
    .picked(picked)
  );

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  // A write holds the bus from its read straight into its write, so
  // nothing can slip in between; the cost is one extra bus cycle.
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (cpuValid && remap && !refuse) begin
          state_d = ST_READ;
        end
      end
      ST_READ: begin
        if (memReady) begin
          state_d = wr_q ? ST_WRITE : ST_DONE;
        end
      end
      ST_WRITE: begin
        if (memReady) begin
          state_d = ST_DONE;
        end
      end
      ST_DONE: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Capture the alias request and the read word
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      addr_q <= 32'h0000_0000;
      size_q <= SIZE_WORD;
      bit_q <= 3'h0;
      wr_q <= 1'b0;
      val_q <= 1'b0;
      word_q <= 32'h0000_0000;
    end else if (state_q == ST_IDLE && cpuValid && remap) begin
      addr_q <= bandAddr;
      size_q <= cpuReq.size;
      bit_q <= bitNum;
      wr_q <= cpuReq.write;
      val_q <= cpuReq.wdata[0];
    end else if (state_q == ST_READ && memReady) begin
      word_q <= memRdata;
    end
  end

  // Read answer word: zero or one only
  logic [31:0] rdata_q;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (state_q == ST_READ && memReady) begin
      rdata_q <= {31'h0000_0000, picked};
    end
  end

  // ------------------------------------------------------------
  // Bus steering
  // ------------------------------------------------------------
  wire logic busy = (state_q != ST_IDLE);
  wire logic inRmw = (state_q == ST_READ) || (state_q == ST_WRITE);
  bbr_req_s rmwReq;
  always_comb begin
    rmwReq.addr = wordAddr | {30'h0000_0000, laneSel};
    rmwReq.size = size_q;
    rmwReq.write = (state_q == ST_WRITE);
    rmwReq.fetch = 1'b0;
    rmwReq.wdata = merged;
  end

  // Direct accesses, band included, go straight to memory
  wire logic passThru = !busy && cpuValid && !remap && !refuse;
  assign memReq = inRmw ? rmwReq : cpuReq;
  assign memValid = inRmw || passThru;
  assign cpuReady = (state_q == ST_DONE) || (passThru && memReady) ||
                    (!busy && cpuValid && refuse);
  assign cpuRdata = (state_q == ST_DONE) ? rdata_q : memRdata;
  assign cpuError = !busy && cpuValid && refuse;

endmodule

// *** bbr_pkg.sv ***
// What this block does
// - Low megabyte of SRAM, peripheral is bit-band
// - Direct SRAM bit-band accesses pass unchanged
// - SRAM alias data remapped, fetches pass through
// - Peripheral alias data remapped, fetches refused
// - Alias offset equals byte times 32 plus bit times 4
// - Decoded bit position ranges zero to seven
// - Memory access keeps alias access size
// - Write bit 0 sets or clears target
// - Written bits 31 to 1 ignored
// - Alias read returns zero or one word
// - Byte lanes are little-endian
package bbr_pkg;

  // ------------------------------------------------------------
  // Address map
  // ------------------------------------------------------------
  localparam logic [31:0] SRAM_BAND_BASE = 32'h2000_0000;
  localparam logic [31:0] SRAM_ALIAS_BASE = 32'h2200_0000;
  localparam logic [31:0] PERI_BAND_BASE = 32'h4000_0000;
  localparam logic [31:0] PERI_ALIAS_BASE = 32'h4200_0000;
  localparam int ALIAS_SPAN_BITS = 25;   // 32 MB alias window
  localparam int BAND_SPAN_BITS = 20;    // 1 MB bit-band window
  localparam int BIT_FIELD_LSB = 2;      // Bit number times 4
  localparam int BYTE_FIELD_LSB = 5;     // Byte offset times 32

  // ------------------------------------------------------------
  // Access size codes
  // ------------------------------------------------------------
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;

  typedef struct packed {
    logic [31:0] addr;
    logic [1:0] size;
    logic write;
    logic fetch;
    logic [31:0] wdata;
  } bbr_req_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_WRITE = 2'b10,
    ST_DONE = 2'b11
  } bbr_state_e;

endpackage

// *** bbr_lane.sv ***
`timescale 1ns/10ps
// Byte-lane helper: places a bit in its little-endian lane and picks it back
module bbr_lane
  import bbr_pkg::*;
(
  input wire logic [1:0] byteSel,   // Byte address within the word
  input wire logic [2:0] bitSel,    // Bit within that byte
  input wire logic [31:0] word,     // Memory word read
  input wire logic newBit,          // Value to store
  output logic [31:0] merged,       // Word with target bit replaced
  output logic picked               // Current target bit
);

  // ------------------------------------------------------------
  // Lane arithmetic
  // ------------------------------------------------------------
  // Lowest byte address sits in bits 7:0
  wire logic [4:0] bitIdx = {byteSel, bitSel};
  wire logic [31:0] oneHot = 32'h0000_0001 << bitIdx;

  assign picked = word[bitIdx];
  // Only the chosen bit changes; neighbours are kept from the read
  assign merged = newBit ? (word | oneHot) : (word & ~oneHot);

endmodule

// *** bbr_mem.sv ***
`timescale 1ns/10ps
// Word memory behind the remapper, stalling at random when asked
module bbr_mem
  import bbr_pkg::*;
(
  input wire logic clock, // Clock
  input wire bbr_req_s memReq, // Request
  input wire logic memValid, // Valid
  input wire logic slow, // Stalls on
  output logic memReady, // Answer
  output logic [31:0] memRdata // Word
);
  logic [31:0] m [16];
  logic go = 1'b1;
  wire logic [3:0] w = memReq.addr[5:2];
  wire logic [1:0] lo = memReq.addr[1:0];
  // Narrow writes touch only their own byte lanes
  wire logic [3:0] be = memReq.size == SIZE_WORD ? 4'hF :
    memReq.size == SIZE_HALF ? 4'h3 << {lo[1], 1'b0} : 4'h1 << lo;
  assign memReady = memValid && go;
  // Outside an answer the bus shows the inverse, so stale data cannot pass
  assign memRdata = memReady ? m[w] : ~m[w];
  initial foreach (m[i]) m[i] = 32'h9C3B_7E10 + i;
  always @(posedge clock) begin
    go <= !slow || $urandom_range(1);
    for (int b = 0; b < 4; b++)
      if (memReady && memReq.write && be[b]) m[w][8*b +: 8] <= memReq.wdata[8*b +: 8];
  end
endmodule

// *** bbr_remapper_chk.sv ***
`timescale 1ns/10ps
module bbr_remapper_chk
  import bbr_pkg::*;
(
  input wire logic clock, // Clock
  input wire logic rst, // Reset
  input wire bbr_req_s cpuReq, // Request
  input wire logic cpuValid, // Valid
  input wire logic cpuReady, // Done
  input wire logic [31:0] cpuRdata, // Data
  input wire logic cpuError, // Refused
  input wire bbr_req_s memReq, // To memory
  input wire logic memValid, // Mem valid
  input wire logic memReady, // Mem done
  input wire logic [31:0] memRdata // Mem data
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Request decode: refused fetch, remapped alias, bit index, read half done
  wire logic [6:0] top = cpuReq.addr[31:25];
  wire logic pf = cpuValid && cpuReq.fetch && top == 7'h21;
  wire logic al = cpuValid && !cpuReq.fetch && (top == 7'h11 || top == 7'h21);
  wire logic [4:0] ix = cpuReq.addr[6:2];
  wire logic rd = al && memValid && memReady && !memReq.write;
  refuse_a: assert property (pf |-> cpuReady && cpuError && !memValid)
    else $error("fetch not refused");
  err_cause_a: assert property (cpuError |-> pf)
    else $error("stray error");
  direct_a: assert property (cpuValid && !al && !pf |-> memValid && memReq == cpuReq
    && cpuReady == memReady) else $error("direct altered");
  band_a: assert property (al && memValid |-> memReq.addr == {cpuReq.addr[31:28], 8'h0,
    cpuReq.addr[24:5]}) else $error("bad band address");
  size_a: assert property (al && memValid |-> memReq.size == cpuReq.size)
    else $error("size changed");
  bit_read_a: assert property (rd && !cpuReq.write |=> cpuReady
    && cpuRdata == {31'h0, $past(memRdata[ix])}) else $error("bad bit word");
  bit_write_a: assert property (rd && cpuReq.write |=> memValid && memReq.write
    && memReq.wdata[ix] == cpuReq.wdata[0]) else $error("bad bit written");
  lanes_kept_a: assert property (rd && cpuReq.write |=>
    ((memReq.wdata ^ $past(memRdata)) & ~(32'h1 << ix)) == 32'h0) else $error("bits lost");
  cover property (rd && cpuReq.write);
  cover property (rd && !cpuReq.write);
  cover property (pf && cpuReady);
endmodule
bind bbr_remapper bbr_remapper_chk bbr_remapper_chk_inst (.clock, .rst, .cpuReq, .cpuValid,
  .cpuReady, .cpuRdata, .cpuError, .memReq, .memValid, .memReady, .memRdata);

// *** testbench.sv ***
`timescale 1ns/10ps
module testbench;
  import bbr_pkg::*;
  logic clock = 0, rst = 1, cpuValid = 0, slow = 0;
  logic cpuReady, cpuError, memValid, memReady;
  logic [31:0] cpuRdata, memRdata, sh [16];
  bbr_req_s cpuReq = '0, memReq;
  logic [33:0] q [$];
  int err_total = 0, checks = 0;
  always #5 clock = ~clock;
  bbr_remapper bbr_remapper_inst (.clock, .rst, .cpuReq, .cpuValid, .cpuReady, .cpuRdata,
    .cpuError, .memReq, .memValid, .memReady, .memRdata);
  bbr_mem bbr_mem_inst (.clock, .memReq, .memValid, .slow, .memReady, .memRdata);
  task automatic cmp(logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: %h not %h", $time, g, e);
    end
  endtask
  task automatic cmp_flag(logic e, g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: flag %b not %b", $time, g, e);
    end
  endtask
  task automatic wrap_up();
    err_total += q.size(); // Unanswered requests count as mismatches
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Note the expectation, then hold the request until it is answered
  task automatic op(logic [31:0] a, logic [1:0] s, logic w, f, ck, er, logic [31:0] d, e);
    q.push_back({ck, er, e});
    cpuReq = '{a, s, w, f, d};
    cpuValid = 1;
    // Look only after the new request has settled, never at the old answer
    @(negedge clock);
    for (int n = 0; n < 60 && cpuReady !== 1'b1; n++) @(negedge clock);
    @(posedge clock);
    #1;
  endtask
  // Each answer is matched with the oldest note
  always @(negedge clock) if (cpuReady === 1'b1) begin
    if (q.size() == 0) cmp_flag(1'b0, cpuReady);
    else begin
      cmp_flag(q[0][32], cpuError);
      if (q[0][33]) cmp(q[0][31:0], cpuRdata);
      void'(q.pop_front());
    end
  end
  initial begin
    logic [31:0] r, d, a, b;
    r = $urandom(23178);
    foreach (sh[i]) sh[i] = 32'h9C3B_7E10 + i;
    repeat (12) @(posedge clock);
    #1 rst = 0;
    for (int t = 0; t < 40; t++) begin
      r = $urandom;
      d = $urandom;
      slow = t > 19;
      a = {r[5] ? 4'h4 : 4'h2, 4'h2, 13'h0, r[9:6], r[4:0], 2'b0};
      b = {a[31:28], 22'h0, r[9:6], 2'b0};
      if (r[10]) begin
        op(b, SIZE_WORD, 1, 0, 0, 0, d, 0);
        sh[r[9:6]] = d;
      end
      op(a, 2'(r[12:11] % 3), 1, 0, 0, 0, d, 0);
      sh[r[9:6]][r[4:0]] = d[0];
      op(a, SIZE_WORD, 0, 0, 1, 0, d, {31'h0, sh[r[9:6]][r[4:0]]});
      op(b, SIZE_WORD, 0, 0, 1, 0, d, sh[r[9:6]]);
    end
    $display("test alias done");
    op(32'h4200_0000, SIZE_WORD, 0, 1, 0, 1, d, 0);
    op(32'h43FF_FFFC, SIZE_BYTE, 0, 1, 0, 1, d, 0);
    op(32'h23FF_FFFC, SIZE_WORD, 0, 1, 1, 0, d, sh[15]);
    cpuValid = 0;
    $display("test fetch done");
    wrap_up();
  end
  // Watchdog well beyond the longest expected run
  initial begin
    #200000;
    err_total++;
    wrap_up();
  end
endmodule
